// file: design/gccr_pkg.sv
package gccr_pkg;
	// register offsets
	localparam logic [11:0] OFS_CTRL_ONE   = 12'h002;
	localparam logic [11:0] OFS_CTRL_TWO   = 12'h004;
	localparam logic [11:0] OFS_PIN_FUNC   = 12'h00a;
	localparam logic [11:0] OFS_STATUS     = 12'h014;
	// control one fields
	localparam int FULL_RST_BIT  = 0;
	localparam int DP_RST_BIT    = 1;
	localparam int CLR_RD_BIT    = 2;
	localparam int PM_SW_BIT     = 3;
	localparam int PM_MODE_LSB   = 4;
	localparam int ERR_SRC_BIT   = 6;
	localparam int SW_ERR_BIT    = 7;
	// control two fields
	localparam int CLOCK_RATE_ADAPTER_REF_SELECT_LSB      = 1;
	localparam int IN_SEL_BIT    = 8;
	localparam int OUT_SEL_BIT   = 9;
	localparam int SRC_LSB       = 10;
	// status fields
	localparam int DONE_BIT      = 0;
	// reset values
	localparam logic       DP_RST_RESET  = 1'b1;
	localparam logic [1:0] PM_MODE_RESET = 2'h0;
	localparam logic [1:0] SRC_RESET     = 2'h0;
	localparam logic [2:0] CLOCK_RATE_ADAPTER_REF_SELECT_RESET    = 3'h0;
	localparam logic [15:0] PIN_FN_RESET = 16'h0000;
	// update mode codes
	localparam logic [1:0] PM_MODE_SW  = 2'h0;
	localparam logic [1:0] PM_MODE_PIN = 2'h1;
	// reference source codes
	localparam logic [1:0] SRC_NONE = 2'h0;
	localparam logic [1:0] SRC_CLOCK_RATE_ADAPTER_REF_SELECT = 2'h1;
	localparam logic [1:0] SRC_PORT = 2'h2;
	// rate adapter reference codes
	localparam logic [2:0] CLOCK_RATE_ADAPTER_REF_SELECT_44M736 = 3'h0;
	localparam logic [2:0] CLOCK_RATE_ADAPTER_REF_SELECT_34M368 = 3'h1;
	localparam logic [2:0] CLOCK_RATE_ADAPTER_REF_SELECT_51M84  = 3'h2;
	localparam logic [2:0] CLOCK_RATE_ADAPTER_REF_SELECT_19M44  = 3'h3;
	localparam logic [2:0] CLOCK_RATE_ADAPTER_REF_SELECT_77M76  = 3'h4;
	// pin function codes
	localparam logic [1:0] PIN_FN_INPUT = 2'h0;
	localparam logic [1:0] PIN_FN_RSVD  = 2'h1;
	localparam logic [1:0] PIN_FN_DRV0  = 2'h2;
	localparam logic [1:0] PIN_FN_DRV1  = 2'h3;
	// pin indices, pin n at index n-1
	localparam int PIN_COUNT = 8;
	localparam int PIN2_IDX  = 1;
	localparam int PIN4_IDX  = 3;
	localparam int PIN6_IDX  = 5;
	localparam int PIN8_IDX  = 7;
	// timing
	localparam int REF8K_PER_SECOND = 8000;
	localparam int CLK_PERIOD_PS    = 4000;
	localparam int RESET_MIN_NS     = 100;
	localparam int RESET_MIN_CYC    = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : gccr_pkg

// file: design/gccr_pin_cell.sv
`timescale 1ns/1ps
module gccr_pin_cell (
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic [1:0] fn_i,
	input  wire logic       force_in_i,
	input  wire logic       force_drv_i,
	input  wire logic       force_val_i,
	// pin
	output logic            pin_o,
	output logic            pin_oe_o
);
	import gccr_pkg::*;

	// registered pin drive, reserved code stays input
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end else if (force_drv_i) begin
			pin_o    <= force_val_i;
			pin_oe_o <= 1'b1;
		end else if (force_in_i || fn_i == PIN_FN_INPUT || fn_i == PIN_FN_RSVD) begin
			pin_o    <= 1'b0;
			pin_oe_o <= 1'b0;
		end else begin
			pin_o    <= (fn_i == PIN_FN_DRV1);
			pin_oe_o <= 1'b1;
		end
	end
endmodule : gccr_pin_cell

// file: design/gccr_sec_div.sv
`timescale 1ns/1ps
module gccr_sec_div #(
	parameter int unsigned EDGES = 8000
) (
	// clock and reset
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	// reference
	input  wire logic en_i,
	input  wire logic ref_i,
	// one second tick
	output logic      tick_o
);
	localparam int CW = $clog2(EDGES);

	initial begin
		if (EDGES < 2) $error("divider needs at least two edges");
	end

	logic          ref_prev_q;
	logic [CW-1:0] cnt_q;

	// count reference rising edges, tick on the last one
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !en_i) begin
			ref_prev_q <= 1'b0;
			cnt_q      <= '0;
			tick_o     <= 1'b0;
		end else begin
			ref_prev_q <= ref_i;
			tick_o     <= 1'b0;
			if (ref_i && !ref_prev_q) begin
				if (cnt_q == CW'(EDGES - 1)) begin
					cnt_q  <= '0;
					tick_o <= 1'b1;
				end else begin
					cnt_q <= cnt_q + 1'b1;
				end
			end
		end
	end
endmodule : gccr_sec_div

// file: design/gccr_top.sv
`timescale 1ns/1ps
// Functional notes
// - error source: software bit or pin 6
// - update mode: bit, pin 8, one-second
// - update rise loads registers, clears counters
// - done status clears when update bit lowered
// - clear mode: 0 on write, 1 on read
// - datapath reset holds defaults, resets to 1
// - full reset defaults all but itself
// - source field picks none, adapter, port
// - one-second tick divides 8 kHz reference
// - input select: pin 4 supplies reference
// - input deselected: pin 4 normal, signal low
// - output select: pin 2 drives reference
// - adapter field declares reference frequency
// - pin field: input, drive 0, drive 1
// - pin 8 field void in mode 01
// - pin 6 field void when pin sourced
// - software insert rise triggers error insertion
module gccr_top #(
	parameter int unsigned REF_EDGES_PER_SEC = gccr_pkg::REF8K_PER_SECOND
) (
	// clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// register port
	input  wire logic [11:0] reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [15:0] reg_rdata_o,
	// general-purpose pins, pin n at index n-1
	input  wire logic [7:0]  gp_pin_i,
	output logic      [7:0]  gp_pin_o,
	output logic      [7:0]  gp_pin_oe_o,
	// reference inputs and update done
	input  wire logic        clock_rate_adapter_ref_select_ref8k_i,
	input  wire logic        port_ref8k_i,
	input  wire logic        pm_update_done_i,
	// controls toward the data path
	output logic             error_insert_o,
	output logic             pm_update_o,
	output logic             latched_clear_on_read_enable_o,
	output logic             datapath_reset_o,
	output logic             full_reset_o,
	output logic             ref8k_output_signal_o,
	output logic             ref8k_input_signal_o,
	output logic             one_second_o,
	output logic      [2:0]  clock_rate_adapter_ref_select_o,
	output logic             clock_rate_adapter_ref_select_ref_valid_o
);
	import gccr_pkg::*;

	initial begin
		if (REF_EDGES_PER_SEC < 2) $error("reference divide too small");
	end

	// control register fields
	logic        software_error_insert_q;
	logic        error_insert_source_select_q;
	logic [1:0]  pm_update_mode_q;
	logic        pm_software_update_q;
	logic        latched_clear_on_read_enable_q;
	logic        datapath_reset_q;
	logic        full_reset_q;
	logic [1:0]  ref8k_source_select_q;
	logic        ref8k_output_select_q;
	logic        ref8k_input_select_q;
	logic [2:0]  clock_rate_adapter_ref_select_q;
	logic [15:0] pin_fn_q;
	logic        pm_update_done_status_q;
	// edge history and helpers
	logic        sw_err_prev_q;
	logic        pm_sw_prev_q;
	logic        pin6_prev_q;
	logic        pin8_prev_q;
	logic        ref8k_q;
	logic        ref_valid_d;
	logic        ref8k_d;
	logic        sec_tick;
	logic        defaults;
	logic        wr_one;
	logic        wr_two;
	logic        wr_fn;
	logic [7:0]  force_in;
	logic [7:0]  force_drv;
	logic [7:0]  force_val;
	logic [$clog2(RESET_MIN_CYC+1)-1:0] rst_hold_q;

	// write decode
	always_comb begin
		wr_one = 1'b0;
		wr_two = 1'b0;
		wr_fn  = 1'b0;
		if (reg_wr_i && reg_addr_i == OFS_CTRL_ONE) begin
			wr_one = 1'b1;
		end else if (reg_wr_i && reg_addr_i == OFS_CTRL_TWO) begin
			wr_two = 1'b1;
		end else if (reg_wr_i && reg_addr_i == OFS_PIN_FUNC) begin
			wr_fn = 1'b1;
		end
	end

	assign defaults = rst_i || full_reset_q;

	// full reset bit, cleared by the general reset or by a control one write of 0
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			full_reset_q <= 1'b0;
		end else if (wr_one) begin
			full_reset_q <= reg_wdata_i[FULL_RST_BIT];
		end
	end

	// control one
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			software_error_insert_q        <= 1'b0;
			error_insert_source_select_q   <= 1'b0;
			pm_update_mode_q               <= PM_MODE_RESET;
			pm_software_update_q           <= 1'b0;
			latched_clear_on_read_enable_q <= 1'b0;
			datapath_reset_q               <= DP_RST_RESET;
		end else if (wr_one) begin
			software_error_insert_q        <= reg_wdata_i[SW_ERR_BIT];
			error_insert_source_select_q   <= reg_wdata_i[ERR_SRC_BIT];
			pm_update_mode_q               <= reg_wdata_i[PM_MODE_LSB +: 2];
			pm_software_update_q           <= reg_wdata_i[PM_SW_BIT];
			latched_clear_on_read_enable_q <= reg_wdata_i[CLR_RD_BIT];
			datapath_reset_q               <= reg_wdata_i[DP_RST_BIT];
		end
	end

	// control two and pin functions
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			ref8k_source_select_q           <= SRC_RESET;
			ref8k_output_select_q           <= 1'b0;
			ref8k_input_select_q            <= 1'b0;
			clock_rate_adapter_ref_select_q <= CLOCK_RATE_ADAPTER_REF_SELECT_RESET;
			pin_fn_q                        <= PIN_FN_RESET;
		end else begin
			if (wr_two) begin
				ref8k_source_select_q           <= reg_wdata_i[SRC_LSB +: 2];
				ref8k_output_select_q           <= reg_wdata_i[OUT_SEL_BIT];
				ref8k_input_select_q            <= reg_wdata_i[IN_SEL_BIT];
				clock_rate_adapter_ref_select_q <= reg_wdata_i[CLOCK_RATE_ADAPTER_REF_SELECT_LSB +: 3];
			end
			if (wr_fn) begin
				pin_fn_q <= reg_wdata_i;
			end
		end
	end

	// update completion status, dropped with the request bit
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			pm_update_done_status_q <= 1'b0;
		end else if (!pm_software_update_q) begin
			pm_update_done_status_q <= 1'b0;
		end else if (pm_update_done_i) begin
			pm_update_done_status_q <= 1'b1;
		end
	end

	// register readback, unmapped reads zero
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 16'h0000;
		end else if (reg_rd_i) begin
			if (reg_addr_i == OFS_CTRL_ONE) begin
				reg_rdata_o <= {8'h00, software_error_insert_q, error_insert_source_select_q,
					pm_update_mode_q, pm_software_update_q, latched_clear_on_read_enable_q,
					datapath_reset_q, full_reset_q};
			end else if (reg_addr_i == OFS_CTRL_TWO) begin
				reg_rdata_o <= {4'h0, ref8k_source_select_q, ref8k_output_select_q,
					ref8k_input_select_q, 4'h0, clock_rate_adapter_ref_select_q, 1'b0};
			end else if (reg_addr_i == OFS_PIN_FUNC) begin
				reg_rdata_o <= pin_fn_q;
			end else if (reg_addr_i == OFS_STATUS) begin
				reg_rdata_o <= {15'h0, pm_update_done_status_q};
			end else begin
				reg_rdata_o <= 16'h0000;
			end
		end
	end

	// edge history for triggers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sw_err_prev_q <= 1'b0;
			pm_sw_prev_q  <= 1'b0;
			pin6_prev_q   <= 1'b0;
			pin8_prev_q   <= 1'b0;
		end else begin
			sw_err_prev_q <= software_error_insert_q;
			pm_sw_prev_q  <= pm_software_update_q;
			pin6_prev_q   <= gp_pin_i[PIN6_IDX];
			pin8_prev_q   <= gp_pin_i[PIN8_IDX];
		end
	end

	// manual error insertion trigger
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			error_insert_o <= 1'b0;
		end else if (error_insert_source_select_q) begin
			error_insert_o <= gp_pin_i[PIN6_IDX] && !pin6_prev_q;
		end else begin
			error_insert_o <= software_error_insert_q && !sw_err_prev_q;
		end
	end

	// performance update trigger: registers load, counters clear
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			pm_update_o <= 1'b0;
		end else begin
			case (pm_update_mode_q)
				PM_MODE_SW:  pm_update_o <= pm_software_update_q && !pm_sw_prev_q;
				PM_MODE_PIN: pm_update_o <= gp_pin_i[PIN8_IDX] && !pin8_prev_q;
				default:     pm_update_o <= sec_tick;
			endcase
		end
	end

	// global 8 kHz reference selection
	always_comb begin
		ref8k_d     = 1'b0;
		ref_valid_d = 1'b0;
		if (ref8k_input_select_q) begin
			ref8k_d     = gp_pin_i[PIN4_IDX];
			ref_valid_d = 1'b1;
		end else begin
			case (ref8k_source_select_q)
				SRC_CLOCK_RATE_ADAPTER_REF_SELECT: begin
					ref8k_d     = clock_rate_adapter_ref_select_ref8k_i;
					ref_valid_d = 1'b1;
				end
				SRC_PORT: begin
					ref8k_d     = port_ref8k_i;
					ref_valid_d = 1'b1;
				end
				default: begin
					ref8k_d     = 1'b0;
					ref_valid_d = 1'b0;
				end
			endcase
		end
	end

	// registered reference and input signal
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			ref8k_q               <= 1'b0;
			ref8k_output_signal_o <= 1'b0;
			ref8k_input_signal_o  <= 1'b0;
		end else begin
			ref8k_q               <= ref8k_d;
			ref8k_output_signal_o <= ref8k_d;
			ref8k_input_signal_o  <= ref8k_input_select_q && gp_pin_i[PIN4_IDX];
		end
	end

	// one-second reference from the selected 8 kHz
	gccr_sec_div #(
		.EDGES (REF_EDGES_PER_SEC)
	) u_sec_div (
		.ref_clk_i (ref_clk_i),
		.rst_i     (defaults),
		.en_i      (ref_valid_d),
		.ref_i     (ref8k_q),
		.tick_o    (sec_tick)
	);

	// one-second output copy
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			one_second_o <= 1'b0;
		end else begin
			one_second_o <= sec_tick;
		end
	end

	// pin overrides from mode bits
	always_comb begin
		force_in  = 8'h00;
		force_drv = 8'h00;
		force_val = 8'h00;
		force_in[PIN4_IDX]  = ref8k_input_select_q;
		force_in[PIN6_IDX]  = error_insert_source_select_q;
		force_in[PIN8_IDX]  = (pm_update_mode_q == PM_MODE_PIN);
		force_drv[PIN2_IDX] = ref8k_output_select_q;
		force_val[PIN2_IDX] = ref8k_q;
	end

	// one cell per pin
	genvar gi;
	generate
		for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
			gccr_pin_cell u_cell (
				.ref_clk_i   (ref_clk_i),
				.rst_i       (defaults),
				.fn_i        (pin_fn_q[2*gi +: 2]),
				.force_in_i  (force_in[gi]),
				.force_drv_i (force_drv[gi]),
				.force_val_i (force_val[gi]),
				.pin_o       (gp_pin_o[gi]),
				.pin_oe_o    (gp_pin_oe_o[gi])
			);
		end
	endgenerate

	// data-path reset, stretched to a safe minimum width
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rst_hold_q       <= '0;
			datapath_reset_o <= 1'b1;
			full_reset_o     <= 1'b0;
		end else begin
			if (datapath_reset_q || full_reset_q) begin
				rst_hold_q <= ($bits(rst_hold_q))'(RESET_MIN_CYC);
			end else if (rst_hold_q != '0) begin
				rst_hold_q <= rst_hold_q - 1'b1;
			end
			datapath_reset_o <= datapath_reset_q || full_reset_q || (rst_hold_q != '0);
			full_reset_o     <= full_reset_q;
		end
	end

	// mode and adapter outputs
	always_ff @(posedge ref_clk_i) begin
		if (defaults) begin
			latched_clear_on_read_enable_o  <= 1'b0;
			clock_rate_adapter_ref_select_o <= CLOCK_RATE_ADAPTER_REF_SELECT_RESET;
			clock_rate_adapter_ref_select_ref_valid_o                <= 1'b1;
		end else begin
			latched_clear_on_read_enable_o  <= latched_clear_on_read_enable_q;
			clock_rate_adapter_ref_select_o <= clock_rate_adapter_ref_select_q;
			clock_rate_adapter_ref_select_ref_valid_o                <= (clock_rate_adapter_ref_select_q <= CLOCK_RATE_ADAPTER_REF_SELECT_77M76);
		end
	end

	// checks
	property p_err_pin;
		@(posedge ref_clk_i) disable iff (defaults)
		(error_insert_source_select_q && gp_pin_i[PIN6_IDX] && !pin6_prev_q) |=> error_insert_o;
	endproperty
	a_err_pin: assert property (p_err_pin) else $error("pin 6 edge missed");

	property p_err_sw;
		@(posedge ref_clk_i) disable iff (defaults)
		(!error_insert_source_select_q && $rose(software_error_insert_q)) |-> ##1 error_insert_o ##1 !error_insert_o;
	endproperty
	a_err_sw: assert property (p_err_sw) else $error("software insert not one pulse");

	property p_pm_pin;
		@(posedge ref_clk_i) disable iff (defaults)
		(pm_update_mode_q == PM_MODE_PIN && gp_pin_i[PIN8_IDX] && !pin8_prev_q) |=> pm_update_o;
	endproperty
	a_pm_pin: assert property (p_pm_pin) else $error("pin 8 update missed");

	property p_pm_sw;
		@(posedge ref_clk_i) disable iff (defaults)
		(pm_update_mode_q == PM_MODE_SW && $rose(pm_software_update_q)) |=> pm_update_o;
	endproperty
	a_pm_sw: assert property (p_pm_sw) else $error("software update missed");

	property p_done_clr;
		@(posedge ref_clk_i) disable iff (defaults)
		!pm_software_update_q |=> !pm_update_done_status_q;
	endproperty
	a_done_clr: assert property (p_done_clr) else $error("done status not cleared");

	property p_clr_mode;
		@(posedge ref_clk_i) disable iff (defaults)
		##1 latched_clear_on_read_enable_o == $past(latched_clear_on_read_enable_q);
	endproperty
	a_clr_mode: assert property (p_clr_mode) else $error("clear mode not passed");

	property p_dp_hold;
		@(posedge ref_clk_i) disable iff (rst_i)
		$fell(datapath_reset_q || full_reset_q) |-> datapath_reset_o [*8];
	endproperty
	a_dp_hold: assert property (p_dp_hold) else $error("datapath reset too short");

	property p_full_defaults;
		@(posedge ref_clk_i) disable iff (rst_i)
		full_reset_q |=> datapath_reset_q && pin_fn_q == PIN_FN_RESET && !ref8k_input_select_q;
	endproperty
	a_full_defaults: assert property (p_full_defaults) else $error("full reset left state");

	property p_ref_none;
		@(posedge ref_clk_i) disable iff (defaults)
		(!ref8k_input_select_q && ref8k_source_select_q == SRC_NONE) |=> !ref8k_q;
	endproperty
	a_ref_none: assert property (p_ref_none) else $error("reference not off");

	property p_in_low;
		@(posedge ref_clk_i) disable iff (defaults)
		!ref8k_input_select_q |=> !ref8k_input_signal_o;
	endproperty
	a_in_low: assert property (p_in_low) else $error("input signal not low");

	property p_pin_overrides;
		@(posedge ref_clk_i) disable iff (defaults)
		(ref8k_output_select_q && error_insert_source_select_q)
		|=> gp_pin_oe_o[PIN2_IDX] && !gp_pin_oe_o[PIN6_IDX];
	endproperty
	a_pin_overrides: assert property (p_pin_overrides) else $error("pin override wrong");

	property p_pin8_input;
		@(posedge ref_clk_i) disable iff (defaults)
		(pm_update_mode_q == PM_MODE_PIN) |=> !gp_pin_oe_o[PIN8_IDX];
	endproperty
	a_pin8_input: assert property (p_pin8_input) else $error("update pin driven");

	property p_pin4_input;
		@(posedge ref_clk_i) disable iff (defaults)
		ref8k_input_select_q |=> !gp_pin_oe_o[PIN4_IDX];
	endproperty
	a_pin4_input: assert property (p_pin4_input) else $error("reference pin driven");

	property p_pin_rsvd;
		@(posedge ref_clk_i) disable iff (defaults)
		(pin_fn_q[1:0] == PIN_FN_RSVD) |=> !gp_pin_oe_o[0];
	endproperty
	a_pin_rsvd: assert property (p_pin_rsvd) else $error("reserved pin driven");
endmodule : gccr_top

// file: sim/gccr_top_tb.sv
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module gccr_top_tb;
	import gccr_pkg::*;
	// one table row: write, read-back and pin state
	typedef struct packed {
		logic [11:0] a;
		logic [15:0] d;
		logic [15:0] r;
		logic [7:0]  oe;
		logic [7:0]  o;
	} gccr_row_t;
	// design inputs
	logic        ref_clk_i     = 1'b0;
	logic        rst_i         = 1'b1;
	logic [11:0] reg_addr_i    = 12'h000;
	logic [15:0] reg_wdata_i   = 16'h0000;
	logic        reg_wr_i      = 1'b0;
	logic        reg_rd_i      = 1'b0;
	logic [7:0]  gp_pin_i      = 8'h00;
	logic        clock_rate_adapter_ref_select_ref8k_i  = 1'b0;
	logic        port_ref8k_i  = 1'b0;
	logic        pm_done_i     = 1'b0;
	// design outputs
	logic [15:0] reg_rdata_o;
	logic [7:0]  gp_pin_o;
	logic [7:0]  gp_pin_oe_o;
	logic        error_insert_o;
	logic        pm_update_o;
	logic        lcr_o;
	logic        datapath_reset_o;
	logic        full_reset_o;
	logic        ref8k_output_signal_o;
	logic        ref8k_input_signal_o;
	logic        one_second_o;
	logic [2:0]  clock_rate_adapter_ref_select_sel_o;
	logic        clock_rate_adapter_ref_select_ref_valid_o;
	// bookkeeping
	int          err_count   = 0;
	int          comparisons = 0;
	int          n_err       = 0;
	int          n_pm        = 0;
	int          n_sec       = 0;
	int          e0;
	int          p0;
	int          s0;
	// writes in order, pins e8e4 leave pins 3,4,6,7,8 driving
	gccr_row_t   rows [12] = '{
		'{OFS_PIN_FUNC, 16'hffff, 16'hffff, 8'hff, 8'hff},
		'{OFS_PIN_FUNC, 16'haaaa, 16'haaaa, 8'hff, 8'h00},
		'{OFS_PIN_FUNC, 16'h5555, 16'h5555, 8'h00, 8'h00},
		'{OFS_PIN_FUNC, 16'he8e4, 16'he8e4, 8'hec, 8'h88},
		'{OFS_CTRL_ONE, 16'h0010, 16'h0010, 8'h6c, 8'h08},
		'{OFS_CTRL_ONE, 16'h0040, 16'h0040, 8'hcc, 8'h88},
		'{OFS_CTRL_ONE, 16'h0000, 16'h0000, 8'hec, 8'h88},
		'{OFS_CTRL_TWO, 16'h0100, 16'h0100, 8'he4, 8'h80},
		'{OFS_CTRL_TWO, 16'h0200, 16'h0200, 8'hee, 8'h88},
		'{OFS_CTRL_TWO, 16'h0000, 16'h0000, 8'hec, 8'h88},
		'{12'h006,      16'h1234, 16'h0000, 8'hec, 8'h88},
		'{OFS_CTRL_ONE, 16'h0004, 16'h0004, 8'hec, 8'h88}
	};

	// 250 MHz clock
	always #2 ref_clk_i = ~ref_clk_i;

	gccr_top #(
		.REF_EDGES_PER_SEC (4)
	) dut (
		.ref_clk_i                       (ref_clk_i),
		.rst_i                           (rst_i),
		.reg_addr_i                      (reg_addr_i),
		.reg_wdata_i                     (reg_wdata_i),
		.reg_wr_i                        (reg_wr_i),
		.reg_rd_i                        (reg_rd_i),
		.reg_rdata_o                     (reg_rdata_o),
		.gp_pin_i                        (gp_pin_i),
		.gp_pin_o                        (gp_pin_o),
		.gp_pin_oe_o                     (gp_pin_oe_o),
		.clock_rate_adapter_ref_select_ref8k_i                    (clock_rate_adapter_ref_select_ref8k_i),
		.port_ref8k_i                    (port_ref8k_i),
		.pm_update_done_i                (pm_done_i),
		.error_insert_o                  (error_insert_o),
		.pm_update_o                     (pm_update_o),
		.latched_clear_on_read_enable_o  (lcr_o),
		.datapath_reset_o                (datapath_reset_o),
		.full_reset_o                    (full_reset_o),
		.ref8k_output_signal_o           (ref8k_output_signal_o),
		.ref8k_input_signal_o            (ref8k_input_signal_o),
		.one_second_o                    (one_second_o),
		.clock_rate_adapter_ref_select_o (clock_rate_adapter_ref_select_sel_o),
		.clock_rate_adapter_ref_select_ref_valid_o                (clock_rate_adapter_ref_select_ref_valid_o)
	);

	// count one-cycle pulses
	always @(posedge ref_clk_i) begin
		if (error_insert_o === 1'b1) n_err++;
		if (pm_update_o === 1'b1) n_pm++;
		if (one_second_o === 1'b1) n_sec++;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc

	// one write, then let outputs and pins settle
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		reg_addr_i  = a;
		reg_wdata_i = d;
		reg_wr_i    = 1'b1;
		@(negedge ref_clk_i);
		reg_wr_i = 1'b0;
		cyc(3);
	endtask : wr

	// one read, data compared a cycle later
	task automatic rd(input logic [11:0] a, input logic [15:0] e);
		@(negedge ref_clk_i);
		reg_addr_i = a;
		reg_rd_i   = 1'b1;
		@(negedge ref_clk_i);
		reg_rd_i = 1'b0;
		@(negedge ref_clk_i);
		`CHK(reg_rdata_o, e)
	endtask : rd

	// pulse the adapter reference n times, three cycles high then three low
	task automatic ref_pulses(input int n);
		repeat (n) begin
			clock_rate_adapter_ref_select_ref8k_i = 1'b1;
			cyc(3);
			clock_rate_adapter_ref_select_ref8k_i = 1'b0;
			cyc(3);
		end
	endtask : ref_pulses

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	// hang guard
	initial begin
		repeat (40000) @(posedge ref_clk_i);
		err_count++;
		$display("ERROR at %0t: run did not finish", $time);
		print_verdict();
	end

	// main sequence
	initial begin
		cyc(20);
		rst_i = 1'b0;
		cyc(1);
		`CHK(datapath_reset_o, 1'b1)
		`CHK(clock_rate_adapter_ref_select_ref_valid_o, 1'b1)
		`CHK(gp_pin_oe_o, 8'h00)
		rd(OFS_CTRL_ONE, 16'h0002);
		rd(OFS_CTRL_TWO, 16'h0000);
		rd(OFS_PIN_FUNC, 16'h0000);
		$display("reset values done");
		wr(OFS_CTRL_ONE, 16'h0000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, rows[i].r);
			`CHK(gp_pin_oe_o, rows[i].oe)
			`CHK(gp_pin_o & gp_pin_oe_o, rows[i].o)
		end
		`CHK(lcr_o, 1'b1)
		wr(OFS_CTRL_ONE, 16'h0000);
		`CHK(lcr_o, 1'b0)
		$display("table done");
		// every adapter code, undefined ones flagged invalid
		for (int k = 0; k < 8; k++) begin
			wr(OFS_CTRL_TWO, 16'(k << 1));
			`CHK(clock_rate_adapter_ref_select_sel_o, k[2:0])
			`CHK(clock_rate_adapter_ref_select_ref_valid_o, (k < 5))
		end
		$display("adapter codes done");
		// datapath reset held 30 cycles, beyond the 100 ns minimum
		wr(OFS_CTRL_ONE, 16'h0002);
		cyc(30);
		`CHK(datapath_reset_o, 1'b1)
		wr(OFS_CTRL_ONE, 16'h0000);
		`CHK(datapath_reset_o, 1'b1)
		cyc(30);
		`CHK(datapath_reset_o, 1'b0)
		$display("datapath reset done");
		// error insertion from software bit, then from pin 6
		e0 = n_err;
		wr(OFS_CTRL_ONE, 16'h0080);
		wr(OFS_CTRL_ONE, 16'h0000);
		gp_pin_i[PIN6_IDX] = 1'b1;
		cyc(3);
		gp_pin_i[PIN6_IDX] = 1'b0;
		cyc(3);
		`CHK(n_err - e0, 1)
		wr(OFS_CTRL_ONE, 16'h0040);
		cyc(4);
		e0 = n_err;
		gp_pin_i[PIN6_IDX] = 1'b1;
		cyc(3);
		gp_pin_i[PIN6_IDX] = 1'b0;
		wr(OFS_CTRL_ONE, 16'h00c0);
		`CHK(n_err - e0, 1)
		wr(OFS_CTRL_ONE, 16'h0000);
		$display("error insertion done");
		// software update with completion handshake
		p0 = n_pm;
		wr(OFS_CTRL_ONE, 16'h0008);
		`CHK(n_pm - p0, 1)
		rd(OFS_STATUS, 16'h0000);
		pm_done_i = 1'b1;
		cyc(3);
		rd(OFS_STATUS, 16'h0001);
		wr(OFS_CTRL_ONE, 16'h0000);
		rd(OFS_STATUS, 16'h0000);
		pm_done_i = 1'b0;
		// pin 8 update mode, software bit then ignored
		wr(OFS_CTRL_ONE, 16'h0010);
		cyc(4);
		p0 = n_pm;
		gp_pin_i[PIN8_IDX] = 1'b1;
		cyc(3);
		gp_pin_i[PIN8_IDX] = 1'b0;
		wr(OFS_CTRL_ONE, 16'h0018);
		wr(OFS_CTRL_ONE, 16'h0010);
		`CHK(n_pm - p0, 1)
		// one-second mode from the adapter reference
		wr(OFS_CTRL_TWO, 16'h0000);
		wr(OFS_CTRL_TWO, 16'h0400);
		wr(OFS_CTRL_ONE, 16'h0020);
		cyc(4);
		p0 = n_pm;
		s0 = n_sec;
		ref_pulses(8);
		cyc(4);
		`CHK(n_sec - s0, 2)
		`CHK(n_pm - p0, 2)
		wr(OFS_CTRL_ONE, 16'h0000);
		$display("update modes done");
		// reference source selection, every code
		for (int k = 0; k < 4; k++) begin
			wr(OFS_CTRL_TWO, 16'(k << 10));
			clock_rate_adapter_ref_select_ref8k_i = 1'b1;
			cyc(4);
			`CHK(ref8k_output_signal_o, (k == 1))
			clock_rate_adapter_ref_select_ref8k_i = 1'b0;
			port_ref8k_i = 1'b1;
			cyc(4);
			`CHK(ref8k_output_signal_o, (k == 2))
			port_ref8k_i = 1'b0;
		end
		wr(OFS_CTRL_TWO, 16'h0700);
		clock_rate_adapter_ref_select_ref8k_i = 1'b1;
		gp_pin_i[PIN4_IDX] = 1'b1;
		cyc(4);
		`CHK(ref8k_input_signal_o, 1'b1)
		`CHK(ref8k_output_signal_o, 1'b1)
		`CHK(gp_pin_o[PIN2_IDX] & gp_pin_oe_o[PIN2_IDX], 1'b1)
		gp_pin_i[PIN4_IDX] = 1'b0;
		cyc(4);
		`CHK(ref8k_output_signal_o, 1'b0)
		`CHK(gp_pin_o[PIN2_IDX], 1'b0)
		clock_rate_adapter_ref_select_ref8k_i = 1'b0;
		gp_pin_i[PIN4_IDX] = 1'b1;
		wr(OFS_CTRL_TWO, 16'h0000);
		`CHK(ref8k_input_signal_o, 1'b0)
		gp_pin_i[PIN4_IDX] = 1'b0;
		$display("reference select done");
		// full reset clears the rest and blocks writes
		wr(OFS_PIN_FUNC, 16'hffff);
		wr(OFS_CTRL_TWO, 16'h0e0e);
		wr(OFS_CTRL_ONE, 16'h0040);
		`CHK(gp_pin_oe_o, 8'hdf)
		`CHK(gp_pin_o & gp_pin_oe_o, 8'hdd)
		wr(OFS_CTRL_ONE, 16'h0001);
		`CHK(full_reset_o, 1'b1)
		`CHK(datapath_reset_o, 1'b1)
		`CHK(gp_pin_oe_o, 8'h00)
		rd(OFS_CTRL_TWO, 16'h0000);
		rd(OFS_PIN_FUNC, 16'h0000);
		wr(OFS_CTRL_TWO, 16'h0200);
		rd(OFS_CTRL_TWO, 16'h0000);
		cyc(30);
		wr(OFS_CTRL_ONE, 16'h0000);
		`CHK(full_reset_o, 1'b0)
		$display("full reset done");
		print_verdict();
	end
endmodule : gccr_top_tb
